// [rtl/stream_framer_pkg.sv]
// Constants and types shared by the IQ and panorama stream framer
package stream_framer_pkg;
  localparam int unsigned ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PANO_SEL = 8'h04;
  localparam logic [7:0] OFF_IQ_SEL = 8'h08;
  localparam logic [7:0] OFF_IQ_RATE = 8'h0C;
  localparam logic [7:0] OFF_IQ_FREQ_LO = 8'h10;
  localparam logic [7:0] OFF_IQ_FREQ_HI = 8'h14;
  localparam logic [7:0] OFF_IQ_BW = 8'h18;
  localparam logic [7:0] OFF_IQ_DEM_ID = 8'h1C;
  localparam logic [7:0] OFF_IQ_DEM_MODE_LO = 8'h20;
  localparam logic [7:0] OFF_IQ_DEM_MODE_HI = 8'h24;
  localparam logic [7:0] OFF_IQ_ITEMS = 8'h28;
  localparam logic [7:0] OFF_PS_START_LO = 8'h2C;
  localparam logic [7:0] OFF_PS_STOP_LO = 8'h30;
  localparam logic [7:0] OFF_PS_STEP = 8'h34;
  localparam logic [7:0] OFF_PS_START_HI = 8'h38;
  localparam logic [7:0] OFF_PS_STOP_HI = 8'h3C;
  localparam logic [7:0] OFF_STATUS = 8'h40;
  localparam logic [7:0] OFF_SEQ_LO = 8'h44;
  // Selector bit positions
  localparam int unsigned SEL_LEVEL = 0;
  localparam int unsigned SEL_FREQ_LO = 1;
  localparam int unsigned SEL_FREQ_HI = 2;
  localparam int unsigned SEL_SWAP = 3;
  localparam int unsigned SEL_OPT_HDR = 4;
  localparam logic [4:0] IQ_SEL_MASK = 5'h10;
  // Control bit positions
  localparam int unsigned CTRL_IQ_EN = 0;
  localparam int unsigned CTRL_PANO_EN = 1;
  // Fixed IQ header contents
  localparam logic [15:0] IQ_MODE = 16'h0001;
  localparam logic [15:0] IQ_FRAME_LEN = 16'h0004;
  localparam logic [15:0] IQ_ATTEN = 16'h0000;
  localparam logic [15:0] IQ_RESERVED = 16'h0000;
  localparam logic [15:0] FLAG_SETTLING = 16'h0000;
  localparam logic [15:0] FLAG_VALID = 16'h0001;
  // Field sizes in bytes and indices of the last header field
  localparam logic [3:0] W2 = 4'h2;
  localparam logic [3:0] W4 = 4'h4;
  localparam logic [3:0] W8 = 4'h8;
  localparam logic [3:0] IQ_HDR_LAST = 4'hB;
  localparam logic [3:0] PANO_HDR_LAST = 4'h4;
  // Panorama FFT length limits
  localparam int unsigned FFT_MIN = 99;
  localparam int unsigned FFT_MAX = 3199;
  localparam int unsigned CNT_W = 12;

  typedef enum logic [2:0] {PH_IDLE, PH_COLLECT, PH_HDR, PH_LVL, PH_FLO, PH_FHI, PH_IQ} phase_t;
  typedef enum logic {K_IQ, K_PANO} kind_t;

  typedef struct packed {
    logic valid;
    logic [15:0] level;
    logic [63:0] freq;
    logic fftLast;
    logic cycleEnd;
  } fft_in_t;

  typedef struct packed {
    logic valid;
    logic [15:0] i;
    logic [15:0] q;
  } iq_in_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic last;
  } byte_out_t;
endpackage : stream_framer_pkg

// [rtl/stream_framer.sv]
// IQ and panorama stream payload framer with APB configuration
// Summary of operation
// - IQ stream carries 16-bit I and Q samples, up to 640 kS/s.
// - IQ format reacts only to the optional-header selector bit.
// - IQ data always goes out in swapped byte order.
// - IQ data only without pano/freq/mem scan, or in freq/mem scan hold.
// - IQ header fields in fixed order, ending with upper frequency word.
// - IQ frame-length field is always 4.
// - IQ validity field is 0 while settling, else 1.
// - Two reserved bytes after validity keep later fields 64-bit aligned.
// - Sample-count field is sequence number of the packet's first IQ sample.
// - Centre frequency split in lower word early, upper word last.
// - Header reports sample rate and resolution bandwidth as 32-bit fields.
// - Panorama FFT holds 99 to 3199 16-bit samples.
// - Panorama honours level, freq_lower_word_select/high, swap and optional-header bits.
// - Panorama data only during panorama scan, one FFT per packet.
// - Panorama header: start lo, stop lo, step, start hi, stop hi.
// - Levels, then lower freq words, then upper freq words, each if selected.
// - End of scan cycle appends end-marker sample to each enabled trace.
// - Header start/stop are user values; first sample is at start frequency.
// - Non-whole span gives one extra sample beyond stop frequency.
// - One scan cycle may span one or more packets.
//
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
module stream_framer #(
  parameter int unsigned DEPTH = stream_framer_pkg::FFT_MAX + 1,
  parameter logic [15:0] LEVEL_MARKER = 16'h0000,
  parameter logic [63:0] FREQ_MARKER = 64'h0000000000000000
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [stream_framer_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic panoScanPin,
  input wire logic frequency_scanPin,
  input wire logic memScanPin,
  input wire logic scanHoldPin,
  input wire logic settlingPin,
  input wire stream_framer_pkg::iq_in_t iqIn,
  output logic iqReady,
  input wire stream_framer_pkg::fft_in_t fftIn,
  output logic fftReady,
  output stream_framer_pkg::byte_out_t outStream,
  input wire logic outReady
);
  typedef struct packed {
    stream_framer_pkg::phase_t phase;
    stream_framer_pkg::kind_t kind;
    logic [4:0] sel;
    logic [stream_framer_pkg::CNT_W-1:0] cnt;
    logic [stream_framer_pkg::CNT_W-1:0] item;
    logic [3:0] fi;
    logic [3:0] bi;
    logic marker;
    logic [63:0] seq;
    logic [63:0] firstSeq;
    logic [4:0] sync1;
    logic [4:0] sync2;
    logic [1:0] ctrl;
    logic [4:0] panoSel;
    logic [4:0] iqSel;
    logic [31:0] iqRate;
    logic [31:0] iqFreqLo;
    logic [31:0] iqFreqHi;
    logic [31:0] iqBw;
    logic [15:0] iqDemId;
    logic [63:0] iqDemMode;
    logic [stream_framer_pkg::CNT_W-1:0] iqItems;
    logic [31:0] psStartLo;
    logic [31:0] psStopLo;
    logic [31:0] psStep;
    logic [31:0] psStartHi;
    logic [31:0] psStopHi;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic iqReady;
    logic fftReady;
    stream_framer_pkg::byte_out_t out;
  } state_t;

  state_t s;
  state_t n;
  logic [79:0] mem [DEPTH];
  logic memWe;
  logic [stream_framer_pkg::CNT_W-1:0] memAddr;
  logic [79:0] memData;

  // Sections follow a fixed order; a clear selector bit skips its section
  function automatic stream_framer_pkg::phase_t nextSection(
      input stream_framer_pkg::phase_t p, input stream_framer_pkg::kind_t k, input logic [4:0] sel);
    nextSection = stream_framer_pkg::PH_IDLE;
    if (p < stream_framer_pkg::PH_HDR && sel[stream_framer_pkg::SEL_OPT_HDR]) begin
      nextSection = stream_framer_pkg::PH_HDR;
    end else if (k == stream_framer_pkg::K_IQ) begin
      if (p != stream_framer_pkg::PH_IQ) begin
        nextSection = stream_framer_pkg::PH_IQ;
      end
    end else if (p < stream_framer_pkg::PH_LVL && sel[stream_framer_pkg::SEL_LEVEL]) begin
      nextSection = stream_framer_pkg::PH_LVL;
    end else if (p < stream_framer_pkg::PH_FLO && sel[stream_framer_pkg::SEL_FREQ_LO]) begin
      nextSection = stream_framer_pkg::PH_FLO;
    end else if (p < stream_framer_pkg::PH_FHI && sel[stream_framer_pkg::SEL_FREQ_HI]) begin
      nextSection = stream_framer_pkg::PH_FHI;
    end
  endfunction : nextSection

  logic [63:0] fv;
  logic [3:0] fw;
  logic [3:0] sh;
  logic [63:0] shifted;
  logic swap;
  logic fieldDone;
  logic sectionDone;
  logic iqAllowed;
  logic panoRun;
  logic apbWrite;
  logic [79:0] rd;
  stream_framer_pkg::phase_t after;

  always_comb begin
    n = s;
    memWe = 1'b0;
    memAddr = s.cnt;
    memData = '0;
    rd = mem[s.item];
    fv = '0;
    fw = stream_framer_pkg::W2;
    n.sync1 = {settlingPin, scanHoldPin, memScanPin, frequency_scanPin, panoScanPin};
    n.sync2 = s.sync1;
    panoRun = s.sync2[0];
    iqAllowed = !panoRun && (!(s.sync2[1] || s.sync2[2]) || s.sync2[3]);

    // APB: one wait state, write and read data at the edge pready is seen
    apbWrite = psel && penable && s.pready && pwrite;
    n.pready = psel && penable && !s.pready;
    // Answer stands only in the pready cycle
    n.pslverr = 1'b0;
    n.prdata = '0;
    if (psel && penable && !s.pready) begin
      if (paddr == stream_framer_pkg::OFF_CTRL) begin
        n.prdata = {30'h0, s.ctrl};
      end else if (paddr == stream_framer_pkg::OFF_PANO_SEL) begin
        n.prdata = {27'h0, s.panoSel};
      end else if (paddr == stream_framer_pkg::OFF_IQ_SEL) begin
        n.prdata = {27'h0, s.iqSel};
      end else if (paddr == stream_framer_pkg::OFF_IQ_RATE) begin
        n.prdata = s.iqRate;
      end else if (paddr == stream_framer_pkg::OFF_IQ_FREQ_LO) begin
        n.prdata = s.iqFreqLo;
      end else if (paddr == stream_framer_pkg::OFF_IQ_FREQ_HI) begin
        n.prdata = s.iqFreqHi;
      end else if (paddr == stream_framer_pkg::OFF_IQ_BW) begin
        n.prdata = s.iqBw;
      end else if (paddr == stream_framer_pkg::OFF_IQ_DEM_ID) begin
        n.prdata = {16'h0, s.iqDemId};
      end else if (paddr == stream_framer_pkg::OFF_IQ_DEM_MODE_LO) begin
        n.prdata = s.iqDemMode[31:0];
      end else if (paddr == stream_framer_pkg::OFF_IQ_DEM_MODE_HI) begin
        n.prdata = s.iqDemMode[63:32];
      end else if (paddr == stream_framer_pkg::OFF_IQ_ITEMS) begin
        n.prdata = {20'h0, s.iqItems};
      end else if (paddr == stream_framer_pkg::OFF_PS_START_LO) begin
        n.prdata = s.psStartLo;
      end else if (paddr == stream_framer_pkg::OFF_PS_STOP_LO) begin
        n.prdata = s.psStopLo;
      end else if (paddr == stream_framer_pkg::OFF_PS_STEP) begin
        n.prdata = s.psStep;
      end else if (paddr == stream_framer_pkg::OFF_PS_START_HI) begin
        n.prdata = s.psStartHi;
      end else if (paddr == stream_framer_pkg::OFF_PS_STOP_HI) begin
        n.prdata = s.psStopHi;
      end else if (paddr == stream_framer_pkg::OFF_STATUS) begin
        n.prdata = {22'h0, s.sync2, s.kind, s.phase, s.marker};
      end else if (paddr == stream_framer_pkg::OFF_SEQ_LO) begin
        n.prdata = s.seq[31:0];
      end else begin
        n.pslverr = 1'b1;
      end
    end
    if (apbWrite) begin
      if (paddr == stream_framer_pkg::OFF_CTRL) begin
        n.ctrl = pwdata[1:0];
      end else if (paddr == stream_framer_pkg::OFF_PANO_SEL) begin
        n.panoSel = pwdata[4:0];
      end else if (paddr == stream_framer_pkg::OFF_IQ_SEL) begin
        n.iqSel = pwdata[4:0];
      end else if (paddr == stream_framer_pkg::OFF_IQ_RATE) begin
        n.iqRate = pwdata;
      end else if (paddr == stream_framer_pkg::OFF_IQ_FREQ_LO) begin
        n.iqFreqLo = pwdata;
      end else if (paddr == stream_framer_pkg::OFF_IQ_FREQ_HI) begin
        n.iqFreqHi = pwdata;
      end else if (paddr == stream_framer_pkg::OFF_IQ_BW) begin
        n.iqBw = pwdata;
      end else if (paddr == stream_framer_pkg::OFF_IQ_DEM_ID) begin
        n.iqDemId = pwdata[15:0];
      end else if (paddr == stream_framer_pkg::OFF_IQ_DEM_MODE_LO) begin
        n.iqDemMode[31:0] = pwdata;
      end else if (paddr == stream_framer_pkg::OFF_IQ_DEM_MODE_HI) begin
        n.iqDemMode[63:32] = pwdata;
      end else if (paddr == stream_framer_pkg::OFF_IQ_ITEMS) begin
        n.iqItems = pwdata[stream_framer_pkg::CNT_W-1:0];
      end else if (paddr == stream_framer_pkg::OFF_PS_START_LO) begin
        n.psStartLo = pwdata;
      end else if (paddr == stream_framer_pkg::OFF_PS_STOP_LO) begin
        n.psStopLo = pwdata;
      end else if (paddr == stream_framer_pkg::OFF_PS_STEP) begin
        n.psStep = pwdata;
      end else if (paddr == stream_framer_pkg::OFF_PS_START_HI) begin
        n.psStartHi = pwdata;
      end else if (paddr == stream_framer_pkg::OFF_PS_STOP_HI) begin
        n.psStopHi = pwdata;
      end
    end

    // Current field value and size
    case (s.phase)
      stream_framer_pkg::PH_HDR: begin
        if (s.kind == stream_framer_pkg::K_IQ) begin
          case (s.fi)
            4'h0: fv = {48'h0, stream_framer_pkg::IQ_MODE};
            4'h1: fv = {48'h0, stream_framer_pkg::IQ_FRAME_LEN};
            4'h2: begin fv = {32'h0, s.iqRate}; fw = stream_framer_pkg::W4; end
            4'h3: begin fv = {32'h0, s.iqFreqLo}; fw = stream_framer_pkg::W4; end
            4'h4: begin fv = {32'h0, s.iqBw}; fw = stream_framer_pkg::W4; end
            4'h5: fv = {48'h0, s.iqDemId};
            4'h6: fv = {48'h0, stream_framer_pkg::IQ_ATTEN};
            4'h7: fv = {48'h0, s.sync2[4] ? stream_framer_pkg::FLAG_SETTLING
                                          : stream_framer_pkg::FLAG_VALID};
            4'h8: fv = {48'h0, stream_framer_pkg::IQ_RESERVED};
            4'h9: begin fv = s.iqDemMode; fw = stream_framer_pkg::W8; end
            4'hA: begin fv = s.firstSeq; fw = stream_framer_pkg::W8; end
            default: begin fv = {32'h0, s.iqFreqHi}; fw = stream_framer_pkg::W4; end
          endcase
        end else begin
          fw = stream_framer_pkg::W4;
          case (s.fi)
            4'h0: fv = {32'h0, s.psStartLo};
            4'h1: fv = {32'h0, s.psStopLo};
            4'h2: fv = {32'h0, s.psStep};
            4'h3: fv = {32'h0, s.psStartHi};
            default: fv = {32'h0, s.psStopHi};
          endcase
        end
      end
      stream_framer_pkg::PH_LVL: fv = {48'h0, rd[79:64]};
      stream_framer_pkg::PH_FLO: begin fv = {32'h0, rd[31:0]}; fw = stream_framer_pkg::W4; end
      stream_framer_pkg::PH_FHI: begin fv = {32'h0, rd[63:32]}; fw = stream_framer_pkg::W4; end
      stream_framer_pkg::PH_IQ: fv = {48'h0, s.fi[0] ? rd[15:0] : rd[31:16]};
      default: fv = '0;
    endcase
    // Swapped order sends the most significant byte first
    swap = (s.kind == stream_framer_pkg::K_IQ) || s.sel[stream_framer_pkg::SEL_SWAP];
    sh = swap ? fw - 4'h1 - s.bi : s.bi;
    shifted = fv >> {sh[2:0], 3'h0};
    fieldDone = (s.bi == fw - 4'h1);
    if (s.phase == stream_framer_pkg::PH_HDR) begin
      sectionDone = fieldDone && (s.fi == ((s.kind == stream_framer_pkg::K_IQ)
          ? stream_framer_pkg::IQ_HDR_LAST : stream_framer_pkg::PANO_HDR_LAST));
    end else if (s.phase == stream_framer_pkg::PH_IQ) begin
      sectionDone = fieldDone && s.fi[0] && (s.item == s.cnt - 1'b1);
    end else begin
      sectionDone = fieldDone && (s.item == s.cnt - 1'b1);
    end
    after = nextSection(s.phase, s.kind, s.sel);

    if (s.out.valid && outReady) begin
      n.out.valid = 1'b0;
      n.out.last = 1'b0;
    end

    case (s.phase)
      stream_framer_pkg::PH_IDLE: begin
        n.cnt = '0;
        n.item = '0;
        n.fi = '0;
        n.bi = '0;
        n.marker = 1'b0;
        if (panoRun && s.ctrl[stream_framer_pkg::CTRL_PANO_EN]) begin
          n.phase = stream_framer_pkg::PH_COLLECT;
          n.kind = stream_framer_pkg::K_PANO;
          n.sel = s.panoSel;
          n.fftReady = 1'b1;
        end else if (iqAllowed && s.ctrl[stream_framer_pkg::CTRL_IQ_EN] && s.iqItems != '0) begin
          n.phase = stream_framer_pkg::PH_COLLECT;
          n.kind = stream_framer_pkg::K_IQ;
          n.sel = s.iqSel & stream_framer_pkg::IQ_SEL_MASK;
          n.firstSeq = s.seq;
          n.iqReady = 1'b1;
        end
      end
      stream_framer_pkg::PH_COLLECT: begin
        if (s.kind == stream_framer_pkg::K_IQ) begin
          if (iqIn.valid && s.iqReady) begin
            memWe = 1'b1;
            memData = {48'h0, iqIn.i, iqIn.q};
            n.cnt = s.cnt + 1'b1;
            n.seq = s.seq + 64'h1;
            if (n.cnt == s.iqItems || n.cnt == DEPTH[stream_framer_pkg::CNT_W-1:0]) begin
              n.iqReady = 1'b0;
              n.phase = after;
            end
          end else if (!iqAllowed) begin
            n.iqReady = 1'b0;
            n.phase = (s.cnt == '0) ? stream_framer_pkg::PH_IDLE : after;
          end
        end else if (s.marker) begin
          // Marker closes every selected trace of the cycle's last packet
          memWe = 1'b1;
          memData = {LEVEL_MARKER, FREQ_MARKER};
          n.cnt = s.cnt + 1'b1;
          n.marker = 1'b0;
          n.phase = after;
        end else if (fftIn.valid && s.fftReady) begin
          memWe = 1'b1;
          memData = {fftIn.level, fftIn.freq};
          n.cnt = s.cnt + 1'b1;
          // Depth holds the longest FFT plus its marker; excess bins close the packet
          if (fftIn.fftLast || n.cnt == DEPTH[stream_framer_pkg::CNT_W-1:0] - 1'b1) begin
            n.fftReady = 1'b0;
            // Packets end per FFT; only the cycle's final one gets a marker
            if (fftIn.cycleEnd) begin
              n.marker = 1'b1;
            end else begin
              n.phase = after;
            end
          end
        end else if (!panoRun) begin
          n.fftReady = 1'b0;
          n.phase = (s.cnt == '0) ? stream_framer_pkg::PH_IDLE : after;
        end
      end
      default: begin
        // Sample count of the packet is taken as delivered, extra bin included
        if (!s.out.valid || outReady) begin
          n.out.valid = 1'b1;
          n.out.data = shifted[7:0];
          n.out.last = sectionDone && (after == stream_framer_pkg::PH_IDLE);
          n.bi = s.bi + 4'h1;
          if (fieldDone) begin
            n.bi = '0;
            if (sectionDone) begin
              n.fi = '0;
              n.item = '0;
              n.phase = after;
            end else if (s.phase == stream_framer_pkg::PH_HDR) begin
              n.fi = s.fi + 4'h1;
            end else if (s.phase == stream_framer_pkg::PH_IQ) begin
              n.fi = {3'h0, !s.fi[0]};
              n.item = s.fi[0] ? s.item + 1'b1 : s.item;
            end else begin
              n.item = s.item + 1'b1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Capture store kept apart from the state word
  always_ff @(posedge clk_sys) begin
    if (memWe) begin
      mem[memAddr] <= memData;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign iqReady = s.iqReady;
  assign fftReady = s.fftReady;
  assign outStream = s.out;
endmodule : stream_framer

// [testbench/stream_client.sv]
// Byte-stream sink standing in for the remote network client
`timescale 1ns/1ps
module stream_client (
  input wire logic clk_sys,
  input wire stream_framer_pkg::byte_out_t outStream,
  output logic outReady
);
  logic [8:0] rxQ[$];
  logic [1:0] stall = 2'h0;
  initial outReady = 1'b0;
  // Refuses one edge in three so that held bytes get exercised
  always @(posedge clk_sys) begin
    stall <= (stall == 2'h2) ? 2'h0 : stall + 2'h1;
    outReady <= (stall != 2'h2);
    if (outStream.valid === 1'b1 && outReady) rxQ.push_back({outStream.last, outStream.data});
  end
endmodule : stream_client

// [testbench/stream_framer_checker.sv]
// Concurrent checks on the framer's ports
`timescale 1ns/1ps
module stream_framer_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [stream_framer_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic iqReady,
  input wire logic fftReady,
  input wire stream_framer_pkg::byte_out_t outStream,
  input wire logic outReady
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic mapped;
  assign mapped = (paddr <= 8'h44) && (paddr[1:0] == 2'h0);
  sequence apb_setup;
    psel && !penable;
  endsequence
  sequence apb_access;
    psel && penable;
  endsequence
  apb_wait_a: assert property (apb_setup ##1 apb_access |-> !pready ##1 pready)
    else $error("pready not in second access cycle");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  slverr_map_a: assert property (apb_access and pready |-> pslverr == !mapped)
    else $error("pslverr does not match address map");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer with data");
  out_hold_a: assert property (outStream.valid && !outReady |=> outStream.valid
    && $stable(outStream.data) && $stable(outStream.last))
    else $error("stalled byte not held");
  ready_excl_a: assert property (!(iqReady && fftReady))
    else $error("both streams collecting");
  reset_quiet_a: assert property ($rose(rst_n) |-> !outStream.valid && !iqReady && !fftReady)
    else $error("outputs active after reset");
  pkt_gap_a: assert property (outStream.valid && outReady && outStream.last |=> !outStream.valid)
    else $error("packet not closed after last byte");
endmodule : stream_framer_checker

bind stream_framer stream_framer_checker chk (.clk_sys(clk_sys), .rst_n(rst_n),
  .paddr(paddr), .psel(psel), .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .iqReady(iqReady), .fftReady(fftReady), .outStream(outStream),
  .outReady(outReady));

// [testbench/iq_and_panorama_stream_framer_bench.sv]
// Self-checking bench for the IQ and panorama stream framer
`timescale 1ns/1ps
module iq_and_panorama_stream_framer_bench;
  localparam logic [15:0] LVL_MK = 16'h8000;
  localparam logic [63:0] FREQ_MK = 64'hFFFFFFFFFFFFFFFE;
  localparam logic [31:0] IQV[7] = '{32'h0009C400, 32'h89ABCDEF, 32'h00000002, 32'h0001D4C0,
    32'h00000005, 32'h41424344, 32'h45464748};
  localparam logic [31:0] PHDR[5] = '{32'h0A000000, 32'h0B000000, 32'h00002710, 32'h00000001,
    32'h00000001};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, iqReady, fftReady, outReady;
  logic panoScanPin = 1'b0;
  logic frequency_scanPin = 1'b0;
  logic memScanPin = 1'b0;
  logic scanHoldPin = 1'b0;
  logic settlingPin = 1'b0;
  stream_framer_pkg::iq_in_t iqIn = '0;
  stream_framer_pkg::fft_in_t fftIn = '0;
  stream_framer_pkg::byte_out_t outStream;
  int error_cnt = 0;
  int compares = 0;
  logic [7:0] expQ[$];
  logic [31:0] rd;
  logic err;

  always #5 clk_sys = ~clk_sys;

  stream_framer #(.LEVEL_MARKER(LVL_MK), .FREQ_MARKER(FREQ_MK)) dut (.clk_sys(clk_sys),
    .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .panoScanPin(panoScanPin), .frequency_scanPin(frequency_scanPin), .memScanPin(memScanPin),
    .scanHoldPin(scanHoldPin), .settlingPin(settlingPin), .iqIn(iqIn), .iqReady(iqReady),
    .fftIn(fftIn), .fftReady(fftReady), .outStream(outStream), .outReady(outReady));
  stream_client client (.clk_sys(clk_sys), .outStream(outStream), .outReady(outReady));

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic timeout(input string what);
    error_cnt++;
    $display("ERROR %s expected answer seen timeout", what);
    give_verdict();
  endtask : timeout

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (int i = 0; i <= 50; i++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
      if (i == 50) timeout("apb");
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Bytes of one field, most significant first when msb is set
  task automatic push(input logic [63:0] v, input int n, input logic msb);
    for (int k = 0; k < n; k++) expQ.push_back(msb ? v[8*(n-1-k) +: 8] : v[8*k +: 8]);
  endtask : push

  // Waits for the whole packet; last must mark only the final byte
  task automatic drain(input string what);
    for (int i = 0; i <= 3000 && client.rxQ.size() < expQ.size(); i++) begin
      @(posedge clk_sys);
      if (i == 3000) timeout(what);
    end
    repeat (8) @(posedge clk_sys);
    check({what, " size"}, expQ.size(), client.rxQ.size());
    foreach (expQ[k]) check(what, {k == expQ.size() - 1, expQ[k]}, client.rxQ[k]);
    expQ.delete();
    client.rxQ.delete();
    $display("%s test done", what);
  endtask : drain

  task automatic apb_case();
    apb(stream_framer_pkg::OFF_CTRL, 1'b0, 32'h0);
    check("ctrl reset", 32'h0, rd);
    apb(stream_framer_pkg::OFF_IQ_ITEMS, 1'b1, 32'hFFFFF002);
    apb(stream_framer_pkg::OFF_IQ_ITEMS, 1'b0, 32'h0);
    check("items", 32'h00000002, rd);
    apb(8'h48, 1'b1, 32'h12345678);
    check("unmapped write err", 32'h1, {31'h0, err});
    apb(8'h48, 1'b0, 32'h0);
    check("unmapped read err", 32'h1, {31'h0, err});
    check("unmapped read data", 32'h0, rd);
    for (int k = 0; k < 7; k++) apb(8'h0C + 8'(4 * k), 1'b1, IQV[k]);
    $display("apb test done");
  endtask : apb_case

  task automatic iq_case(input logic hdr, input logic settle, input logic [63:0] seq);
    int sent;
    sent = 0;
    settlingPin <= settle;
    apb(stream_framer_pkg::OFF_IQ_SEL, 1'b1, hdr ? 32'h17 : 32'h0F);
    if (hdr) begin
      push(stream_framer_pkg::IQ_MODE, 2, 1'b1);
      push(stream_framer_pkg::IQ_FRAME_LEN, 2, 1'b1);
      push(IQV[0], 4, 1'b1);
      push(IQV[1], 4, 1'b1);
      push(IQV[3], 4, 1'b1);
      push(IQV[4][15:0], 2, 1'b1);
      push(stream_framer_pkg::IQ_ATTEN, 2, 1'b1);
      push(settle ? 16'h0000 : 16'h0001, 2, 1'b1);
      push(stream_framer_pkg::IQ_RESERVED, 2, 1'b1);
      push({IQV[6], IQV[5]}, 8, 1'b1);
      push(seq, 8, 1'b1);
      push(IQV[2], 4, 1'b1);
    end
    for (int k = 0; k < 2; k++) begin
      push(16'hA100 + 16'(k), 2, 1'b1);
      push(16'h5100 + 16'(k), 2, 1'b1);
    end
    iqIn <= '{1'b1, 16'hA100, 16'h5100};
    apb(stream_framer_pkg::OFF_CTRL, 1'b1, 32'h1);
    for (int i = 0; i < 300 && sent < 2; i++) begin
      @(posedge clk_sys);
      if (iqReady === 1'b1) begin
        sent++;
        iqIn <= '{sent < 2, 16'hA100 + 16'(sent), 16'h5100 + 16'(sent)};
      end
    end
    // Off before the packet ends, else a new collection opens
    apb(stream_framer_pkg::OFF_CTRL, 1'b1, 32'h0);
    drain(hdr ? "iq header" : "iq bare");
  endtask : iq_case

  // Frequency scan running blocks the IQ stream until hold
  task automatic iq_blocked();
    frequency_scanPin <= 1'b1;
    iqIn <= '{1'b1, 16'hA100, 16'h5100};
    apb(stream_framer_pkg::OFF_CTRL, 1'b1, 32'h1);
    repeat (20) @(posedge clk_sys);
    check("iqReady in scan", 32'h0, {31'h0, iqReady});
    apb(stream_framer_pkg::OFF_CTRL, 1'b1, 32'h0);
    scanHoldPin <= 1'b1;
    memScanPin <= 1'b1;
    $display("iq blocked test done");
  endtask : iq_blocked

  task automatic pano_case(input logic sw);
    int sent;
    sent = 0;
    apb(stream_framer_pkg::OFF_PANO_SEL, 1'b1, sw ? 32'h1B : 32'h13);
    for (int k = 0; k < 5; k++) begin
      apb(stream_framer_pkg::OFF_PS_START_LO + 8'(4 * k), 1'b1, PHDR[k]);
      push(PHDR[k], 4, sw);
    end
    for (int k = 0; k < 2; k++) push(16'h0300 + 16'(k), 2, sw);
    push(LVL_MK, 2, sw);
    for (int k = 0; k < 2; k++) push(32'h0A000000 + 32'(k) * 32'h2710, 4, sw);
    push(FREQ_MK[31:0], 4, sw);
    panoScanPin <= 1'b1;
    fftIn <= '{1'b1, 16'h0300, {32'h1, 32'h0A000000}, 1'b0, 1'b0};
    apb(stream_framer_pkg::OFF_CTRL, 1'b1, 32'h2);
    for (int i = 0; i < 300 && sent < 2; i++) begin
      @(posedge clk_sys);
      if (fftReady === 1'b1) begin
        sent++;
        // Bin frequency is start plus n steps, as the client expects
        fftIn <= '{sent < 2, 16'h0300 + 16'(sent), {32'h1, 32'h0A000000 + 32'(sent) * 32'h2710},
          sent == 1, sent == 1};
      end
    end
    apb(stream_framer_pkg::OFF_CTRL, 1'b1, 32'h0);
    drain(sw ? "panorama swapped" : "panorama");
    panoScanPin <= 1'b0;
  endtask : pano_case

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb_case();
    iq_case(1'b1, 1'b0, 64'h0);
    iq_case(1'b1, 1'b1, 64'h2);
    iq_blocked();
    iq_case(1'b0, 1'b0, 64'h4);
    apb(stream_framer_pkg::OFF_SEQ_LO, 1'b0, 32'h0);
    check("sequence count", 32'h00000006, rd);
    frequency_scanPin <= 1'b0;
    scanHoldPin <= 1'b0;
    memScanPin <= 1'b0;
    pano_case(1'b0);
    pano_case(1'b1);
    give_verdict();
  end
endmodule : iq_and_panorama_stream_framer_bench
